// ---- design/fbs_bitput.sv ----
`timescale 1ns/1ns
`default_nettype none
// Replaces one indexed bit of a word, combinational
module fbs_bitput #(
    parameter int W = 8,
    parameter int IW = 3
) (
    // Word, position and new bit
    input wire logic [W-1:0] value_in,
    input wire logic [IW-1:0] index_in,
    input wire logic bit_in,
    // Modified word
    output logic [W-1:0] value_out
);

    // Only the addressed bit changes
    always_comb begin
        value_out = value_in;
        value_out[index_in] = bit_in;
    end

endmodule
`default_nettype wire

// ---- design/fbs_exec_unit.sv ----
// Functional notes
// - Half-carry branches jump to pc plus offset plus one when the flag matches
// - T-flag branches jump by offset plus one only when T matches
// - Overflow branches jump to pc plus offset plus one when V matches
// - Interrupt-state branches jump when the global enable is one or zero
// - I/O bit raise sets the addressed bit, flags untouched, two cycles
// - I/O bit drop clears the addressed bit, flags untouched, two cycles
// - Logical shift up fills bit zero with zero, updates Z C N V
// - Logical shift down fills bit seven with zero, updates Z C N V
// - Rotate up takes carry into bit zero, old bit seven into carry
// - Rotate down takes carry into bit seven, old bit zero into carry
// - Arithmetic shift down keeps the sign bit, updates Z C N V
// - Bit-to-T copies one source bit into T, nothing else changes
// - T-to-bit writes T into one destination bit, flags unchanged
// - Single-flag set and clear forms, named or by index, one cycle
// - Global interrupt on and off set or clear I in one cycle
// - Signed test flag set and clear in one cycle, others kept
// - Overflow flag set and clear in one cycle, others kept
// - Register copy moves source to destination in one cycle, flags kept
`timescale 1ns/1ns
`default_nettype none
module fbs_exec_unit
    import fbs_pkg::*;
(
    // Clock, reset and enable
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Instruction issue
    input wire logic op_valid_in,
    input wire fbs_op_t op_code_in,
    input wire logic [GPR_IDX_W-1:0] op_rd_in,
    input wire logic [GPR_IDX_W-1:0] op_rr_in,
    input wire logic [BIT_IDX_W-1:0] op_bit_in,
    input wire logic [IO_IDX_W-1:0] op_io_in,
    input wire logic [OFS_W-1:0] op_offset_in,
    // Execution status
    output logic op_ready_out,
    output logic op_done_out,
    output logic branch_taken_out,
    output logic [PC_W-1:0] pc_out,
    output logic [DATA_W-1:0] status_out,
    // Register port
    input wire logic [BUS_ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out
);

    // Architectural state
    logic [DATA_W-1:0] gpr_q [GPR_COUNT];
    logic [DATA_W-1:0] io_q [IO_COUNT];
    logic [DATA_W-1:0] status_q;
    logic [PC_W-1:0] pc_q;

    // Sequencer state
    fbs_state_t state_q;
    logic ready_q;
    logic done_q;
    logic taken_q;
    logic [IO_IDX_W-1:0] pend_io_idx_q;
    logic [DATA_W-1:0] pend_io_val_q;
    logic [PC_W-1:0] pend_pc_q;
    logic [DATA_W-1:0] rdata_q;

    // Operands and decoded results
    logic accept;
    logic [DATA_W-1:0] rd_val, rr_val, io_val;
    logic [DATA_W-1:0] shift_res;
    logic shift_c;
    logic [DATA_W-1:0] shift_status;
    logic [DATA_W-1:0] bld_res;
    logic [DATA_W-1:0] io_new;
    logic flag_hit;
    logic [BIT_IDX_W-1:0] flag_idx;
    logic flag_val;
    logic [DATA_W-1:0] flag_status;
    logic is_branch;
    logic br_cond;
    logic is_io_op;
    logic [PC_W-1:0] pc_seq, pc_target;
    logic gpr_we;
    logic [DATA_W-1:0] gpr_wdata;
    logic status_we;
    logic [DATA_W-1:0] status_wdata;
    logic [DATA_W-1:0] read_mux;

    // Register port region decode
    logic bus_gpr_hit;
    logic bus_io_hit;
    assign bus_gpr_hit = reg_addr_in[BUS_ADDR_W-1:GPR_IDX_W]
                         == BUS_GPR_BASE[BUS_ADDR_W-1:GPR_IDX_W];
    assign bus_io_hit = reg_addr_in[BUS_ADDR_W-1:IO_IDX_W]
                        == BUS_IO_BASE[BUS_ADDR_W-1:IO_IDX_W];

    // Issue handshake and operand fetch
    assign accept = clk_en_in & op_valid_in & ready_q;
    assign rd_val = gpr_q[op_rd_in];
    assign rr_val = gpr_q[op_rr_in];
    assign io_val = io_q[op_io_in];

    // Sequential and relative next program counter
    assign pc_seq = pc_q + PC_STEP;
    assign pc_target = pc_q + {{(PC_W-OFS_W){op_offset_in[OFS_W-1]}}, op_offset_in} + PC_STEP;

    // Shift and rotate datapath
    fbs_shift u_shift (
        .op_in(op_code_in),
        .value_in(rd_val),
        .carry_in(status_q[FLAG_C]),
        .result_out(shift_res),
        .carry_out(shift_c)
    );

    // Flags after a shift: Z C N V only, V is N xor C
    always_comb begin
        shift_status = status_q;
        shift_status[FLAG_C] = shift_c;
        shift_status[FLAG_Z] = (shift_res == DATA_RESET);
        shift_status[FLAG_N] = shift_res[DATA_W-1];
        shift_status[FLAG_V] = shift_res[DATA_W-1] ^ shift_c;
    end

    // T flag into a destination bit
    fbs_bitput #(.W(DATA_W), .IW(BIT_IDX_W)) u_bld (
        .value_in(rd_val),
        .index_in(op_bit_in),
        .bit_in(status_q[FLAG_T]),
        .value_out(bld_res)
    );

    // I/O register bit raise or drop
    fbs_bitput #(.W(DATA_W), .IW(BIT_IDX_W)) u_io (
        .value_in(io_val),
        .index_in(op_bit_in),
        .bit_in(op_code_in == OP_IO_BIT_RAISE),
        .value_out(io_new)
    );

    // Single status flag update
    fbs_bitput #(.W(DATA_W), .IW(BIT_IDX_W)) u_flag (
        .value_in(status_q),
        .index_in(flag_idx),
        .bit_in(flag_val),
        .value_out(flag_status)
    );

    // Which flag a flag operation touches
    always_comb begin
        flag_hit = 1'b1;
        flag_idx = op_bit_in;
        case (op_code_in)
            OP_FLAG_INDEX_RAISE, OP_FLAG_INDEX_DROP: flag_idx = op_bit_in;
            OP_CARRY_RAISE, OP_CARRY_DROP: flag_idx = FLAG_C;
            OP_NEGATIVE_RAISE, OP_NEGATIVE_DROP: flag_idx = FLAG_N;
            OP_ZERO_RAISE, OP_ZERO_DROP: flag_idx = FLAG_Z;
            OP_T_FLAG_RAISE, OP_T_FLAG_DROP: flag_idx = FLAG_T;
            OP_HALFCARRY_RAISE, OP_HALFCARRY_DROP: flag_idx = FLAG_H;
            OP_IRQ_GLOBAL_ON, OP_IRQ_GLOBAL_OFF: flag_idx = FLAG_I;
            OP_SIGNED_RAISE, OP_SIGNED_DROP: flag_idx = FLAG_S;
            OP_OVERFLOW_RAISE, OP_OVERFLOW_DROP: flag_idx = FLAG_V;
            OP_BIT_TO_TFLAG: flag_idx = FLAG_T;
            default: flag_hit = 1'b0;
        endcase
    end

    // Raise forms write one, bit-to-T the source bit, drop forms zero
    assign flag_val = (op_code_in == OP_BIT_TO_TFLAG) ? rr_val[op_bit_in]
        : op_code_in inside {OP_FLAG_INDEX_RAISE, OP_CARRY_RAISE, OP_NEGATIVE_RAISE,
        OP_ZERO_RAISE, OP_T_FLAG_RAISE, OP_HALFCARRY_RAISE, OP_IRQ_GLOBAL_ON,
        OP_SIGNED_RAISE, OP_OVERFLOW_RAISE};

    // Branch decode and condition test
    always_comb begin
        is_branch = 1'b1;
        br_cond = 1'b0;
        case (op_code_in)
            OP_BRANCH_HALFCARRY_HIGH: br_cond = status_q[FLAG_H];
            OP_BRANCH_HALFCARRY_LOW: br_cond = ~status_q[FLAG_H];
            OP_BRANCH_TFLAG_HIGH: br_cond = status_q[FLAG_T];
            OP_BRANCH_TFLAG_LOW: br_cond = ~status_q[FLAG_T];
            OP_BRANCH_OVERFLOW_HIGH: br_cond = status_q[FLAG_V];
            OP_BRANCH_OVERFLOW_LOW: br_cond = ~status_q[FLAG_V];
            OP_BRANCH_IRQ_ENABLED: br_cond = status_q[FLAG_I];
            OP_BRANCH_IRQ_DISABLED: br_cond = ~status_q[FLAG_I];
            default: is_branch = 1'b0;
        endcase
    end

    assign is_io_op = (op_code_in == OP_IO_BIT_RAISE) | (op_code_in == OP_IO_BIT_DROP);

    // Register file and status writes of one-cycle operations
    always_comb begin
        gpr_we = 1'b1;
        gpr_wdata = shift_res;
        status_we = 1'b1;
        status_wdata = shift_status;
        case (op_code_in)
            OP_LOGIC_SHIFT_UP, OP_LOGIC_SHIFT_DOWN, OP_ROTATE_UP_CARRY,
            OP_ROTATE_DOWN_CARRY, OP_ARITH_SHIFT_DOWN: gpr_wdata = shift_res;
            OP_NIBBLE_SWAP: begin
                gpr_wdata = {rd_val[NIB_W-1:0], rd_val[DATA_W-1:NIB_W]};
                status_we = 1'b0;
            end
            OP_TFLAG_TO_BIT: begin
                gpr_wdata = bld_res;
                status_we = 1'b0;
            end
            OP_REGISTER_COPY: begin
                gpr_wdata = rr_val;
                status_we = 1'b0;
            end
            default: begin
                gpr_we = 1'b0;
                status_we = flag_hit;
                status_wdata = flag_status;
            end
        endcase
    end

    // Sequencer: two-cycle I/O bit writes and taken branches
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            taken_q <= 1'b0;
            pend_io_idx_q <= '0;
            pend_io_val_q <= DATA_RESET;
            pend_pc_q <= PC_RESET;
        end else if (clk_en_in) begin
            done_q <= 1'b0;
            taken_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        if (is_io_op) begin
                            state_q <= ST_IO_WRITE;
                            ready_q <= 1'b0;
                            pend_io_idx_q <= op_io_in;
                            pend_io_val_q <= io_new;
                        end else if (is_branch && br_cond) begin
                            state_q <= ST_BRANCH;
                            ready_q <= 1'b0;
                            pend_pc_q <= pc_target;
                        end else begin
                            done_q <= 1'b1;
                        end
                    end
                end
                ST_IO_WRITE, ST_BRANCH: begin
                    state_q <= ST_IDLE;
                    ready_q <= 1'b1;
                    done_q <= 1'b1;
                    taken_q <= (state_q == ST_BRANCH);
                end
                default: begin
                    state_q <= ST_IDLE;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    // Program counter: execution has priority over the register port
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pc_q <= PC_RESET;
        end else if (clk_en_in) begin
            if (state_q == ST_BRANCH) begin
                pc_q <= pend_pc_q;
            end else if (state_q == ST_IO_WRITE
                         || (accept && !is_io_op && !(is_branch && br_cond))) begin
                pc_q <= pc_seq;
            end else if (reg_wr_in && reg_addr_in == BUS_PC_LO) begin
                pc_q[DATA_W-1:0] <= reg_wdata_in;
            end else if (reg_wr_in && reg_addr_in == BUS_PC_HI) begin
                pc_q[PC_W-1:DATA_W] <= reg_wdata_in[PC_W-DATA_W-1:0];
            end
        end
    end

    // Status flags: execution has priority over the register port
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_q <= STATUS_RESET;
        end else if (clk_en_in) begin
            if (accept && status_we) begin
                status_q <= status_wdata;
            end else if (reg_wr_in && reg_addr_in == BUS_STATUS) begin
                status_q <= reg_wdata_in;
            end
        end
    end

    // General purpose registers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < GPR_COUNT; i++) begin
                gpr_q[i] <= DATA_RESET;
            end
        end else if (clk_en_in) begin
            if (accept && gpr_we) begin
                gpr_q[op_rd_in] <= gpr_wdata;
            end else if (reg_wr_in && bus_gpr_hit) begin
                gpr_q[reg_addr_in[GPR_IDX_W-1:0]] <= reg_wdata_in;
            end
        end
    end

    // I/O registers, second cycle of a bit write commits
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < IO_COUNT; i++) begin
                io_q[i] <= DATA_RESET;
            end
        end else if (clk_en_in) begin
            if (state_q == ST_IO_WRITE) begin
                io_q[pend_io_idx_q] <= pend_io_val_q;
            end else if (reg_wr_in && bus_io_hit) begin
                io_q[reg_addr_in[IO_IDX_W-1:0]] <= reg_wdata_in;
            end
        end
    end

    // Register port read selection, unmapped reads zero
    always_comb begin
        read_mux = DATA_RESET;
        if (bus_gpr_hit) begin
            read_mux = gpr_q[reg_addr_in[GPR_IDX_W-1:0]];
        end else if (bus_io_hit) begin
            read_mux = io_q[reg_addr_in[IO_IDX_W-1:0]];
        end else if (reg_addr_in == BUS_STATUS) begin
            read_mux = status_q;
        end else if (reg_addr_in == BUS_PC_LO) begin
            read_mux = pc_q[DATA_W-1:0];
        end else if (reg_addr_in == BUS_PC_HI) begin
            read_mux = {{(2*DATA_W-PC_W){1'b0}}, pc_q[PC_W-1:DATA_W]};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= DATA_RESET;
        end else if (clk_en_in) begin
            rdata_q <= reg_rd_in ? read_mux : DATA_RESET;
        end
    end

    // Outputs straight from flip-flops
    assign op_ready_out = ready_q;
    assign op_done_out = done_q;
    assign branch_taken_out = taken_q;
    assign pc_out = pc_q;
    assign status_out = status_q;
    assign reg_rdata_out = rdata_q;

endmodule
`default_nettype wire

// ---- design/fbs_pkg.sv ----
`default_nettype none
// Shared constants and types of the flag, branch, bit and shift unit
package fbs_pkg;

    // Datapath widths
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int BIT_IDX_W = 3;
    localparam int GPR_COUNT = 32;
    localparam int GPR_IDX_W = 5;
    localparam int IO_COUNT = 32;
    localparam int IO_IDX_W = 5;
    localparam int PC_W = 12;
    localparam int OFS_W = 7;
    localparam int BUS_ADDR_W = 8;

    // Register port map
    localparam logic [BUS_ADDR_W-1:0] BUS_GPR_BASE = 8'h00;
    localparam logic [BUS_ADDR_W-1:0] BUS_IO_BASE = 8'h20;
    localparam logic [BUS_ADDR_W-1:0] BUS_STATUS = 8'h40;
    localparam logic [BUS_ADDR_W-1:0] BUS_PC_LO = 8'h41;
    localparam logic [BUS_ADDR_W-1:0] BUS_PC_HI = 8'h42;

    // Bit positions inside status_q
    localparam logic [BIT_IDX_W-1:0] FLAG_C = 3'h0;
    localparam logic [BIT_IDX_W-1:0] FLAG_Z = 3'h1;
    localparam logic [BIT_IDX_W-1:0] FLAG_N = 3'h2;
    localparam logic [BIT_IDX_W-1:0] FLAG_V = 3'h3;
    localparam logic [BIT_IDX_W-1:0] FLAG_S = 3'h4;
    localparam logic [BIT_IDX_W-1:0] FLAG_H = 3'h5;
    localparam logic [BIT_IDX_W-1:0] FLAG_T = 3'h6;
    localparam logic [BIT_IDX_W-1:0] FLAG_I = 3'h7;

    // Reset values and fixed increments
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;

    // Operation codes
    typedef enum logic [5:0] {
        OP_NOP,
        OP_BRANCH_HALFCARRY_HIGH,
        OP_BRANCH_HALFCARRY_LOW,
        OP_BRANCH_TFLAG_HIGH,
        OP_BRANCH_TFLAG_LOW,
        OP_BRANCH_OVERFLOW_HIGH,
        OP_BRANCH_OVERFLOW_LOW,
        OP_BRANCH_IRQ_ENABLED,
        OP_BRANCH_IRQ_DISABLED,
        OP_IO_BIT_RAISE,
        OP_IO_BIT_DROP,
        OP_LOGIC_SHIFT_UP,
        OP_LOGIC_SHIFT_DOWN,
        OP_ROTATE_UP_CARRY,
        OP_ROTATE_DOWN_CARRY,
        OP_ARITH_SHIFT_DOWN,
        OP_NIBBLE_SWAP,
        OP_FLAG_INDEX_RAISE,
        OP_FLAG_INDEX_DROP,
        OP_BIT_TO_TFLAG,
        OP_TFLAG_TO_BIT,
        OP_CARRY_RAISE,
        OP_CARRY_DROP,
        OP_NEGATIVE_RAISE,
        OP_NEGATIVE_DROP,
        OP_ZERO_RAISE,
        OP_ZERO_DROP,
        OP_IRQ_GLOBAL_ON,
        OP_IRQ_GLOBAL_OFF,
        OP_SIGNED_RAISE,
        OP_SIGNED_DROP,
        OP_OVERFLOW_RAISE,
        OP_OVERFLOW_DROP,
        OP_T_FLAG_RAISE,
        OP_T_FLAG_DROP,
        OP_HALFCARRY_RAISE,
        OP_HALFCARRY_DROP,
        OP_REGISTER_COPY
    } fbs_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_IO_WRITE,
        ST_BRANCH
    } fbs_state_t;

endpackage
`default_nettype wire

// ---- design/fbs_shift.sv ----
`timescale 1ns/1ns
`default_nettype none
// Shift and rotate datapath, combinational
module fbs_shift
    import fbs_pkg::*;
(
    // Operation and operands
    input wire fbs_op_t op_in,
    input wire logic [DATA_W-1:0] value_in,
    input wire logic carry_in,
    // Result
    output logic [DATA_W-1:0] result_out,
    output logic carry_out
);

    // One shift form per operation
    always_comb begin
        result_out = value_in;
        carry_out = carry_in;
        case (op_in)
            OP_LOGIC_SHIFT_UP: begin
                result_out = {value_in[DATA_W-2:0], 1'b0};
                carry_out = value_in[DATA_W-1];
            end
            OP_LOGIC_SHIFT_DOWN: begin
                result_out = {1'b0, value_in[DATA_W-1:1]};
                carry_out = value_in[0];
            end
            OP_ROTATE_UP_CARRY: begin
                result_out = {value_in[DATA_W-2:0], carry_in};
                carry_out = value_in[DATA_W-1];
            end
            OP_ROTATE_DOWN_CARRY: begin
                result_out = {carry_in, value_in[DATA_W-1:1]};
                carry_out = value_in[0];
            end
            OP_ARITH_SHIFT_DOWN: begin
                result_out = {value_in[DATA_W-1], value_in[DATA_W-1:1]};
                carry_out = value_in[0];
            end
            default: begin
                result_out = value_in;
                carry_out = carry_in;
            end
        endcase
    end

endmodule
`default_nettype wire

// ---- test/fbs_exec_unit_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module fbs_exec_sva
    import fbs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Issue side
    input wire logic clk_en_in,
    input wire logic op_valid_in,
    input wire fbs_op_t op_code_in,
    input wire logic [OFS_W-1:0] op_offset_in,
    // Status side
    input wire logic op_ready_out,
    input wire logic op_done_out,
    input wire logic branch_taken_out,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic [DATA_W-1:0] status_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    logic go;
    logic [PC_W-1:0] tgt_q;
    // Issue accepted at this edge
    assign go = clk_en_in && op_valid_in && op_ready_out;
    // Branch target as seen at issue
    always_ff @(posedge clock_in) begin
        tgt_q <= pc_out + PC_W'($signed(op_offset_in)) + PC_STEP;
    end
    property p_shift;
        go && op_code_in == OP_LOGIC_SHIFT_UP |=> op_done_out && pc_out == $past(pc_out) + PC_STEP
            && status_out[3] == (status_out[2] ^ status_out[0]) && $stable(status_out[6:4]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift flags or pc wrong");
    property p_br;
        go && op_code_in == OP_BRANCH_TFLAG_HIGH && status_out[FLAG_T] |=> !op_ready_out
            && !op_done_out ##1 op_done_out && branch_taken_out && pc_out == $past(tgt_q);
    endproperty
    a_br: assert property (p_br) else $error("taken branch wrong");
    property p_nt;
        go && op_code_in == OP_BRANCH_OVERFLOW_HIGH && !status_out[FLAG_V] |=> op_done_out
            && !branch_taken_out && op_ready_out && pc_out == $past(pc_out) + PC_STEP;
    endproperty
    a_nt: assert property (p_nt) else $error("untaken branch wrong");
    property p_io;
        go && (op_code_in == OP_IO_BIT_RAISE || op_code_in == OP_IO_BIT_DROP) |=>
            !op_ready_out && $stable(status_out) ##1 op_done_out && $stable(status_out);
    endproperty
    a_io: assert property (p_io) else $error("io bit op timing");
    property p_td;
        branch_taken_out |-> op_done_out && op_ready_out;
    endproperty
    a_td: assert property (p_td) else $error("taken without done");
    property p_carry;
        go && op_code_in == OP_CARRY_RAISE |=> status_out == ($past(status_out) | 8'h01);
    endproperty
    a_carry: assert property (p_carry) else $error("carry raise wrong");
    property p_irq;
        go && op_code_in == OP_IRQ_GLOBAL_OFF |=> status_out == ($past(status_out) & 8'h7F);
    endproperty
    a_irq: assert property (p_irq) else $error("irq off wrong");
    property p_sev;
        go && op_code_in == OP_OVERFLOW_RAISE |=> status_out == ($past(status_out) | 8'h08);
    endproperty
    a_sev: assert property (p_sev) else $error("overflow raise wrong");
    property p_keep;
        go && op_code_in inside {OP_NIBBLE_SWAP, OP_REGISTER_COPY, OP_TFLAG_TO_BIT} |=>
            op_done_out && $stable(status_out);
    endproperty
    a_keep: assert property (p_keep) else $error("flags changed");
endmodule
bind fbs_exec_unit fbs_exec_sva fbs_exec_sva_inst (.clock_in, .sys_rst_in, .clk_en_in,
    .op_valid_in, .op_code_in, .op_offset_in, .op_ready_out, .op_done_out,
    .branch_taken_out, .pc_out, .status_out);
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb
    import fbs_pkg::*;
;
    localparam logic [2:0] BFL [4] = '{FLAG_H, FLAG_T, FLAG_V, FLAG_I};
    localparam logic [2:0] FFL [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T,
        FLAG_H};
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic op_valid_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    fbs_op_t op_code_in = OP_NOP;
    logic [4:0] op_rd_in = '0, op_rr_in = '0, op_io_in = '0;
    logic [2:0] op_bit_in = '0;
    logic [6:0] op_offset_in = '0;
    logic [7:0] reg_addr_in = '0, reg_wdata_in = '0;
    logic op_ready_out, op_done_out, branch_taken_out;
    logic [PC_W-1:0] pc_out, pcm;
    logic [7:0] status_out, reg_rdata_out, sm;
    logic [7:0] gm [32];
    logic [7:0] im [32];
    logic [31:0] seed = 32'h0000DAC4;
    logic [31:0] w;
    int fails = 0, check_count = 0, cycles = 0;
    fbs_exec_unit fbs_exec_unit_inst (.clock_in, .sys_rst_in, .clk_en_in, .op_valid_in,
        .op_code_in, .op_rd_in, .op_rr_in, .op_bit_in, .op_io_in, .op_offset_in,
        .op_ready_out, .op_done_out, .branch_taken_out, .pc_out, .status_out,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
    // Clock and hang guard
    initial begin
        forever #10 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(12'(reg_rdata_out), 12'(exp));
    endtask
    // Model one op, issue it, compare cycles, pc, flags and registers
    task automatic run(input fbs_op_t op, input logic [4:0] d, input logic [4:0] r,
        input logic [2:0] b, input logic [4:0] p, input logic [6:0] k);
        int n;
        int ec;
        logic [7:0] v;
        logic c;
        ec = 1;
        v = gm[d];
        c = sm[0];
        case (op) inside
            [OP_BRANCH_HALFCARRY_HIGH:OP_BRANCH_IRQ_DISABLED]: begin
                if (sm[BFL[(op - 1) / 2]] == op[0]) begin
                    pcm = pcm + PC_W'($signed(k));
                    ec = 2;
                end
            end
            OP_IO_BIT_RAISE, OP_IO_BIT_DROP: begin
                im[p][b] = (op == OP_IO_BIT_RAISE);
                ec = 2;
            end
            OP_LOGIC_SHIFT_UP: {c, v} = {v, 1'b0};
            OP_LOGIC_SHIFT_DOWN: {v, c} = {1'b0, v};
            OP_ROTATE_UP_CARRY: {c, v} = {v, sm[0]};
            OP_ROTATE_DOWN_CARRY: {v, c} = {sm[0], v};
            OP_ARITH_SHIFT_DOWN: {v, c} = {v[7], v};
            OP_NIBBLE_SWAP: v = {v[3:0], v[7:4]};
            OP_FLAG_INDEX_RAISE, OP_FLAG_INDEX_DROP: sm[b] = (op == OP_FLAG_INDEX_RAISE);
            OP_BIT_TO_TFLAG: sm[FLAG_T] = gm[r][b];
            OP_TFLAG_TO_BIT: v[b] = sm[FLAG_T];
            OP_REGISTER_COPY: v = gm[r];
            [OP_CARRY_RAISE:OP_HALFCARRY_DROP]: sm[FFL[(op - OP_CARRY_RAISE) / 2]] = op[0];
            default: ;
        endcase
        if (op inside {[OP_LOGIC_SHIFT_UP:OP_ARITH_SHIFT_DOWN]}) begin
            sm[3:0] = {v[7] ^ c, v[7], v == 8'h00, c};
        end
        gm[d] = v;
        pcm = pcm + PC_STEP;
        @(posedge clock_in);
        op_valid_in <= 1'b1;
        op_code_in <= op;
        op_rd_in <= d;
        op_rr_in <= r;
        op_bit_in <= b;
        op_io_in <= p;
        op_offset_in <= k;
        @(posedge clock_in);
        op_valid_in <= 1'b0;
        n = 1;
        #1;
        while (op_done_out !== 1'b1 && n < 4) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        chk(12'(n), 12'(ec));
        chk(12'(branch_taken_out), 12'(ec == 2 && op < OP_IO_BIT_RAISE));
        chk(pc_out, pcm);
        chk(12'(status_out), 12'(sm));
        rd(BUS_GPR_BASE + 8'(d), gm[d]);
        rd(BUS_IO_BASE + 8'(p), im[p]);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        #1;
        chk({op_ready_out, op_done_out, branch_taken_out, 1'b0, status_out}, 12'h800);
        chk(pc_out, PC_RESET);
        for (int i = 0; i < 64; i++) begin
            w = rnd();
            if (i < 32) gm[i] = w[7:0];
            else im[i - 32] = w[7:0];
            wr(8'(i), w[7:0]);
        end
        wr(8'h80, 8'hFF);
        rd(8'h80, 8'h00);
        clk_en_in <= 1'b0;
        wr(8'h00, ~gm[0]);
        clk_en_in <= 1'b1;
        rd(8'h00, gm[0]);
        wr(BUS_PC_HI, 8'hFF);
        wr(BUS_PC_LO, 8'hF0);
        pcm = 12'hFF0;
        rd(BUS_PC_HI, 8'h0F);
        for (int i = 1; i <= 8; i++)
            for (int j = 0; j < 2; j++) begin
                sm = j ? 8'hFF : 8'h00;
                wr(BUS_STATUS, sm);
                run(fbs_op_t'(i), 5'h00, 5'h00, 3'h0, 5'h00, j ? 7'h40 : 7'h3F);
            end
        for (int i = 11; i <= 15; i++) begin
            gm[3] = i[0] ? 8'h80 : 8'h01;
            wr(8'h03, gm[3]);
            run(fbs_op_t'(i), 5'h03, 5'h00, 3'h0, 5'h00, 7'h00);
        end
        repeat (300) begin
            w = rnd();
            run(fbs_op_t'(w[31:26] % 38), w[4:0], w[9:5], w[12:10], w[17:13], w[24:18]);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
